/* File: frmc_map.svh */
// Register offsets, field positions, reset values and address bounds for the flash mode control block
`ifndef FRMC_MAP_SVH
`define FRMC_MAP_SVH

// Register word offsets (byte addresses)
`define FRMC_OFF_MODE_CTRL 4'h0
`define FRMC_OFF_PROC_MODE 4'h4
`define FRMC_OFF_STATUS 4'h8
`define FRMC_OFF_REQUEST 4'hC

// Mode control register fields
`define FRMC_BIT_SW_REWRITE_EN 1
`define FRMC_BIT_FLASH_SUBMODE 2
`define FRMC_BIT_BOOT_SELECT 5

// Processor mode register one fields
`define FRMC_BIT_EXTRA_BLOCK_EN 0
`define FRMC_BIT_RESERVED_EXPAND 3

// Request register fields
`define FRMC_REQ_CMD_LSB 0
`define FRMC_REQ_CMD_MSB 2
`define FRMC_REQ_BLOCK_LSB 8
`define FRMC_REQ_BLOCK_MSB 11
`define FRMC_REQ_BYTE 16
`define FRMC_REQ_FETCH_FLASH 17
`define FRMC_REQ_BOOT_TARGET 18

// Status register fields
`define FRMC_ST_MODE_LSB 0
`define FRMC_ST_MODE_MSB 2
`define FRMC_ST_ACCEPT 4
`define FRMC_ST_REFUSE 5
`define FRMC_ST_EXP_SHOWN 6
`define FRMC_ST_BOOT_VIS 7

// Reset values
`define FRMC_RST_MODE_CTRL 8'h00
`define FRMC_RST_PROC_MODE 8'h00

// Address bounds
`define FRMC_EXP_LO 20'h40000
`define FRMC_EXP_HI 20'hBFFFF
`define FRMC_CS2_LO 20'h10000
`define FRMC_CS2_HI 20'h26FFF
`define FRMC_EXTRA_BLOCK_BYTES 4096
`define FRMC_BOOT_BLOCK_BYTES 4096

`endif

/* File: frmc_pkg.sv */
// Types shared by the flash mode control block
package frmc_pkg;

    // Single-chip, expansion, boot and parallel operation, chosen at reset
    typedef enum logic [2:0] {
        FRMC_OP_SINGLE = 3'h0,
        FRMC_OP_EXPAND = 3'h1,
        FRMC_OP_BOOT = 3'h2,
        FRMC_OP_PARALLEL = 3'h3
    } frmc_op_t;

    // Eight software commands
    typedef enum logic [2:0] {
        FRMC_CMD_READ_ARRAY = 3'h0,
        FRMC_CMD_READ_STATUS = 3'h1,
        FRMC_CMD_CLEAR_STATUS = 3'h2,
        FRMC_CMD_PROGRAM = 3'h3,
        FRMC_CMD_BLOCK_ERASE = 3'h4,
        FRMC_CMD_ERASE_ALL = 3'h5,
        FRMC_CMD_LOCK_PROGRAM = 3'h6,
        FRMC_CMD_READ_LOCK = 3'h7
    } frmc_cmd_t;

    // Bus slave states
    typedef enum logic [1:0] {
        FRMC_BUS_IDLE = 2'b00,
        FRMC_BUS_ANSWER = 2'b01
    } frmc_bus_t;

endpackage

/* File: frmc_ctrl.sv */
// Flash rewrite mode selection, address map control and command gating
`timescale 1ns/1ps
`include "frmc_map.svh"

// Functional notes
// [R1] Three rewrite modes: software, serial, parallel
// [R2] Boot block rewritable only in parallel mode
// [R3] Word programming; bytes only in parallel mode
// [R4] Program and erase only via eight commands
// [R5] Collective erase and single block erase
// [R6] Locked user block refuses program and erase
// [R7] RAM-run submode versus flash-run submode
// [R8] Outside single-chip, only RAM-run submode allowed
// [R9] Serial mode in boot, user area only
// [R10] Parallel mode rewrites boot and user areas
// [R11] Rewrite enable forces expansion bit to one
// [R12] Expansion bit writes deferred until enable clears
// [R13] Entering rewrite sets extra block, expansion bits
// [R14] Expansion bit zero hides 40000h to BFFFFh
// [R15] Extra block enable moves chip select two area
// [R16] User area includes separate 4-Kbyte extra block
// [R17] Boot and user areas share addresses
// [R18] Boot pins pattern at reset selects boot area
// [R19] Processor mode pin low runs user program
// [R20] Ordinary reads never return boot contents
// [R21] Boot select bit picks boot or user array
// [R22] Pins sampled once at reset release
module frmc_ctrl #(
    parameter int NUM_BLOCKS = 16,
    parameter int EXTRA_BLOCK = 15
) (
    input wire logic sys_clk_i,  // 250 MHz system clock
    input wire logic rst_n_i,  // Synchronous reset, active low
    input wire logic processor_mode_pin_i,  // Processor mode strap pin
    input wire logic boot_select_high_pin_i,  // Boot select pin, high for boot
    input wire logic boot_select_low_pin_i,  // Boot select pin, low for boot
    input wire logic parallel_prog_i,  // Parallel programmer attached (level)
    input wire logic serial_sync_i,  // Serial programmer uses clocked transfer
    input wire logic [3:0] avs_address_i,  // Byte address
    input wire logic avs_read_i,  // Read strobe
    input wire logic avs_write_i,  // Write strobe
    input wire logic [31:0] avs_writedata_i,  // Write data
    input wire logic [3:0] avs_byteenable_i,  // Byte lanes
    output logic [31:0] avs_readdata_o,  // Read data
    output logic avs_waitrequest_o,  // Stall until answer
    input wire logic [19:0] cpu_addr_i,  // CPU fetch or read address
    output logic boot_area_select_o,  // Array accesses reach boot area
    output logic ext_area_enable_o,  // Expanded area usable
    output logic cs2_area_hit_o,  // Address falls in chip select two area
    output logic extra_block_enable_o,  // Extra block mapped
    output logic cmd_start_o,  // One-cycle command start pulse
    output logic [2:0] cmd_code_o,  // Command code with start
    output logic [3:0] cmd_block_o,  // Target block with start
    output logic cmd_byte_o  // Byte unit program with start
);

    initial begin
        if (NUM_BLOCKS < 2 || NUM_BLOCKS > 16 || EXTRA_BLOCK >= NUM_BLOCKS) begin
            $error("frmc_ctrl: unsupported block parameters");
        end
    end

    typedef struct packed {
        frmc_pkg::frmc_bus_t bus;
        logic [31:0] rdata;
        logic wait_n;
        logic sampled;
        frmc_pkg::frmc_op_t op;
        logic serial_sync;
        logic rewrite_en;
        logic flash_submode;
        logic boot_sel;
        logic extra_en;
        logic expand_user;
        logic expand_pending;
        logic expand_pend_val;
        logic [15:0] lock;
        logic accept;
        logic refuse;
        logic start;
        logic [2:0] code;
        logic [3:0] blk;
        logic bytemode;
        logic boot_vis;
        logic ext_en;
        logic cs2_hit;
    } frmc_state_t;

    frmc_state_t st;
    frmc_state_t next_st;

    logic bsh_s1, bsh_s2, bsl_s1, bsl_s2, pm_s1, pm_s2, par_s1, par_s2;

    // Two-flop synchronisers for strap pins; only the second flop is read
    always_ff @(posedge sys_clk_i) begin
        bsh_s1 <= boot_select_high_pin_i;
        bsh_s2 <= bsh_s1;
        bsl_s1 <= boot_select_low_pin_i;
        bsl_s2 <= bsl_s1;
        pm_s1 <= processor_mode_pin_i;
        pm_s2 <= pm_s1;
        par_s1 <= parallel_prog_i;
        par_s2 <= par_s1;
    end

    logic expand_shown;
    logic [7:0] mode_ctrl_rd;
    logic [7:0] proc_mode_rd;
    logic [7:0] status_rd;
    logic [19:0] cpu_addr;
    assign cpu_addr = cpu_addr_i;
    // Rewrite enable forces the expansion bit; user value hides behind it
    assign expand_shown = st.rewrite_en | st.expand_user; // see [R11]
    assign mode_ctrl_rd = 8'h00 | (8'(st.rewrite_en) << `FRMC_BIT_SW_REWRITE_EN)
        | (8'(st.flash_submode) << `FRMC_BIT_FLASH_SUBMODE) | (8'(st.boot_sel) << `FRMC_BIT_BOOT_SELECT);
    assign proc_mode_rd = (8'(st.extra_en) << `FRMC_BIT_EXTRA_BLOCK_EN)
        | (8'(expand_shown) << `FRMC_BIT_RESERVED_EXPAND);
    assign status_rd = 8'(st.op) | (8'(st.accept) << `FRMC_ST_ACCEPT) | (8'(st.refuse) << `FRMC_ST_REFUSE)
        | (8'(expand_shown) << `FRMC_ST_EXP_SHOWN) | (8'(st.boot_vis) << `FRMC_ST_BOOT_VIS);

    // Next-state logic: strap capture, bus slave, register effects, command gate
    always_comb begin
        logic wr;
        logic rd;
        logic [31:0] wd;
        logic [2:0] c;
        logic [3:0] b;
        logic by;
        logic fetch_flash;
        logic boot_tgt;
        logic ok;
        logic new_en;
        wr = 1'b0;
        rd = 1'b0;
        wd = avs_writedata_i;
        c = wd[`FRMC_REQ_CMD_MSB:`FRMC_REQ_CMD_LSB];
        b = wd[`FRMC_REQ_BLOCK_MSB:`FRMC_REQ_BLOCK_LSB];
        by = wd[`FRMC_REQ_BYTE];
        fetch_flash = wd[`FRMC_REQ_FETCH_FLASH];
        boot_tgt = wd[`FRMC_REQ_BOOT_TARGET];
        ok = 1'b1;
        new_en = st.rewrite_en;
        next_st = st;
        next_st.start = 1'b0;

        // Mode taken once, on the first cycle after reset release
        if (!st.sampled) begin
            next_st.sampled = 1'b1;
            next_st.serial_sync = serial_sync_i;
            if (par_s2) begin
                next_st.op = frmc_pkg::FRMC_OP_PARALLEL; // see [R10]
            end else if (pm_s2 && bsh_s2 && !bsl_s2) begin
                next_st.op = frmc_pkg::FRMC_OP_BOOT; // see [R18]
                next_st.boot_sel = 1'b1; // see [R22]
            end else if (pm_s2) begin
                next_st.op = frmc_pkg::FRMC_OP_EXPAND;
            end else begin
                next_st.op = frmc_pkg::FRMC_OP_SINGLE; // see [R19]
            end
        end

        // Avalon slave: one wait cycle, answer on the second cycle
        // Read data is latched when the request is seen so it stands while waitrequest is low
        case (st.bus)
            frmc_pkg::FRMC_BUS_IDLE: begin
                next_st.wait_n = 1'b0;
                if (avs_read_i || avs_write_i) begin
                    next_st.bus = frmc_pkg::FRMC_BUS_ANSWER;
                    next_st.wait_n = 1'b1;
                    rd = avs_read_i;
                end
            end
            frmc_pkg::FRMC_BUS_ANSWER: begin
                next_st.bus = frmc_pkg::FRMC_BUS_IDLE;
                next_st.wait_n = 1'b0;
                wr = avs_write_i;
            end
            default: begin
                next_st.bus = frmc_pkg::FRMC_BUS_IDLE;
                next_st.wait_n = 1'b0;
            end
        endcase

        if (rd) begin
            if (avs_address_i == `FRMC_OFF_MODE_CTRL) begin
                next_st.rdata = {24'h000000, mode_ctrl_rd};
            end else if (avs_address_i == `FRMC_OFF_PROC_MODE) begin
                next_st.rdata = {24'h000000, proc_mode_rd};
            end else if (avs_address_i == `FRMC_OFF_STATUS) begin
                next_st.rdata = {24'h000000, status_rd};
            end else begin
                next_st.rdata = 32'h00000000;
            end
        end

        if (wr && avs_byteenable_i[0]) begin
            if (avs_address_i == `FRMC_OFF_MODE_CTRL) begin
                new_en = wd[`FRMC_BIT_SW_REWRITE_EN];
                next_st.rewrite_en = new_en;
                // Flash-run submode only in single-chip operation
                next_st.flash_submode = wd[`FRMC_BIT_FLASH_SUBMODE]
                    && st.op == frmc_pkg::FRMC_OP_SINGLE; // see [R7] see [R8]
                // Boot select only meaningful in boot operation
                if (st.op == frmc_pkg::FRMC_OP_BOOT) begin
                    next_st.boot_sel = wd[`FRMC_BIT_BOOT_SELECT]; // see [R21]
                end
                if (new_en && !st.rewrite_en) begin
                    next_st.extra_en = 1'b1; // see [R13]
                end
                if (!new_en && st.expand_pending) begin
                    next_st.expand_user = st.expand_pend_val; // see [R12]
                    next_st.expand_pending = 1'b0;
                end
            end else if (avs_address_i == `FRMC_OFF_PROC_MODE) begin
                next_st.extra_en = wd[`FRMC_BIT_EXTRA_BLOCK_EN]; // see [R15]
                if (st.rewrite_en) begin
                    next_st.expand_pending = 1'b1; // see [R12]
                    next_st.expand_pend_val = wd[`FRMC_BIT_RESERVED_EXPAND];
                end else begin
                    next_st.expand_user = wd[`FRMC_BIT_RESERVED_EXPAND];
                end
            end else if (avs_address_i == `FRMC_OFF_REQUEST) begin
                // Array changes start only through a command; see [R4]
                if (c == frmc_pkg::FRMC_CMD_PROGRAM || c == frmc_pkg::FRMC_CMD_BLOCK_ERASE
                    || c == frmc_pkg::FRMC_CMD_ERASE_ALL) begin // see [R5]
                    if (st.op == frmc_pkg::FRMC_OP_PARALLEL) begin
                        ok = 1'b1; // see [R1] see [R10]
                    end else if (st.op == frmc_pkg::FRMC_OP_BOOT && !st.rewrite_en) begin
                        ok = !boot_tgt; // see [R9]
                    end else begin
                        ok = st.rewrite_en;
                        // RAM-run submode refuses a request fetched from flash
                        if (fetch_flash && !st.flash_submode) begin
                            ok = 1'b0; // see [R7]
                        end
                    end
                    if (boot_tgt && st.op != frmc_pkg::FRMC_OP_PARALLEL) begin
                        ok = 1'b0; // see [R2]
                    end
                    if (by && st.op != frmc_pkg::FRMC_OP_PARALLEL) begin
                        ok = 1'b0; // see [R3]
                    end
                    if (c != frmc_pkg::FRMC_CMD_ERASE_ALL && !boot_tgt && st.lock[b]) begin
                        ok = 1'b0; // see [R6]
                    end
                    if (32'(b) >= NUM_BLOCKS) begin
                        ok = 1'b0;
                    end
                end else if (c == frmc_pkg::FRMC_CMD_LOCK_PROGRAM) begin
                    ok = st.rewrite_en || st.op == frmc_pkg::FRMC_OP_PARALLEL;
                    if (ok) begin
                        next_st.lock[b] = 1'b1;
                    end
                end
                // Collective erase opens every lock
                if (ok && c == frmc_pkg::FRMC_CMD_ERASE_ALL) begin
                    next_st.lock = 16'h0000;
                end
                next_st.accept = ok;
                next_st.refuse = !ok;
                next_st.start = ok;
                next_st.code = c;
                next_st.blk = b;
                next_st.bytemode = by;
            end
        end

        // Boot contents visible only in boot operation with select set
        next_st.boot_vis = next_st.op == frmc_pkg::FRMC_OP_BOOT && next_st.boot_sel; // see [R17] see [R20]
        // Expansion window closed while bit is zero
        next_st.ext_en = (next_st.rewrite_en | next_st.expand_user)
            || cpu_addr < `FRMC_EXP_LO || cpu_addr > `FRMC_EXP_HI; // see [R14]
        // Chip select two window only with extra block mapped
        next_st.cs2_hit = next_st.extra_en
            && cpu_addr >= `FRMC_CS2_LO && cpu_addr <= `FRMC_CS2_HI; // see [R15] see [R16]
    end

    // State register; reset clears all control state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.op <= frmc_pkg::FRMC_OP_SINGLE;
            st.bus <= frmc_pkg::FRMC_BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = !st.wait_n;
    assign boot_area_select_o = st.boot_vis;
    assign ext_area_enable_o = st.ext_en;
    assign cs2_area_hit_o = st.cs2_hit;
    assign extra_block_enable_o = st.extra_en;
    assign cmd_start_o = st.start;
    assign cmd_code_o = st.code;
    assign cmd_block_o = st.blk;
    assign cmd_byte_o = st.bytemode;

endmodule

/* File: frmc_properties.sv */
// Port-level checker for the flash mode control block
`timescale 1ns/1ps
module frmc_checker (
    input wire logic sys_clk_i,  // Clock
    input wire logic rst_n_i,  // Reset, active low
    input wire logic processor_mode_pin_i,  // Strap
    input wire logic boot_select_high_pin_i,  // Strap
    input wire logic boot_select_low_pin_i,  // Strap
    input wire logic parallel_prog_i,  // Strap
    input wire logic [3:0] avs_address_i,  // Address
    input wire logic avs_read_i,  // Read
    input wire logic avs_write_i,  // Write
    input wire logic [31:0] avs_writedata_i,  // Write data
    input wire logic [31:0] avs_readdata_o,  // Read data
    input wire logic avs_waitrequest_o,  // Stall
    input wire logic [19:0] cpu_addr_i,  // CPU address
    input wire logic boot_area_select_o,  // Boot area
    input wire logic ext_area_enable_o,  // Expanded area usable
    input wire logic cs2_area_hit_o,  // Chip select two hit
    input wire logic extra_block_enable_o,  // Extra block
    input wire logic cmd_start_o,  // Command pulse
    input wire logic [2:0] cmd_code_o,  // Command code
    input wire logic [3:0] cmd_block_o  // Command block
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Bus answer shape: one idle cycle, then one answer cycle
    sequence s_req_seen;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    sequence s_req_accept;
        avs_write_i && !avs_waitrequest_o && avs_address_i == 4'hC;
    endsequence
    logic in_cs2;
    logic in_exp;
    assign in_cs2 = cpu_addr_i >= 20'h10000 && cpu_addr_i <= 20'h26FFF;
    assign in_exp = cpu_addr_i >= 20'h40000 && cpu_addr_i <= 20'hBFFFF;
    a_bus_answer: assert property (s_req_seen |=> s_answer) else $error("bus answer late");
    a_read_narrow: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000 &&
        (avs_address_i[1:0] == 2'b00 || avs_readdata_o == 32'h00000000)) else $error("read data wide");
    a_cmd_cause: assert property (cmd_start_o |-> $past(avs_write_i && !avs_waitrequest_o && avs_address_i == 4'hC))
        else $error("command without request");
    a_cmd_fields: assert property (s_req_accept ##1 cmd_start_o |-> cmd_code_o == $past(avs_writedata_i[2:0]) &&
        cmd_block_o == $past(avs_writedata_i[11:8])) else $error("command fields wrong");
    a_cmd_pulse: assert property (cmd_start_o |=> !cmd_start_o) else $error("command pulse long");
    a_outside_exp: assert property (!in_exp |=> ext_area_enable_o) else $error("area wrongly hidden");
    a_cs2_hit: assert property (in_cs2 && extra_block_enable_o |=> cs2_area_hit_o) else $error("cs2 hit lost");
    a_cs2_range: assert property (!in_cs2 |=> !cs2_area_hit_o) else $error("cs2 hit outside");
    a_boot_only: assert property (boot_area_select_o |-> processor_mode_pin_i && boot_select_high_pin_i &&
        !boot_select_low_pin_i && !parallel_prog_i) else $error("boot area outside boot");
endmodule
bind frmc_ctrl frmc_checker i_chk(.*);

/* File: frmc_strap_model.sv */
// Board and programmer strap model: drives mode pins for a chosen start-up
`timescale 1ns/1ps
module frmc_strap_model (
    input wire logic [1:0] mode_i,  // 0 single, 1 expand, 2 boot, 3 parallel
    input wire logic serial_i,  // Serial variant choice
    output logic pm_pin_o,  // Processor mode pin
    output logic bs_high_o,  // Boot select high pin
    output logic bs_low_o,  // Boot select low pin
    output logic par_o,  // Parallel programmer attached
    output logic ser_sync_o  // Clocked serial variant
);
    // Pins are static levels; the bench only moves mode_i inside reset
    assign pm_pin_o = mode_i != 2'd0;
    assign bs_high_o = mode_i == 2'd2;
    assign bs_low_o = 1'b0;
    assign par_o = mode_i == 2'd3;
    assign ser_sync_o = serial_i;
endmodule

/* File: tb_top.sv */
// Self-checking bench for the flash mode control block
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, ser = 0;
    logic [1:0] mode = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [19:0] caddr = 20'h00000;
    logic wreq, pm, bsh, bsl, par, ssync, boot_sel, ext_en, cs2, xblk, cst, cbyte;
    logic [2:0] ccode;
    logic [3:0] cblk;
    logic [31:0] rq[$], mq[$];
    logic [6:0] cq[$];
    integer err_total = 0, comparisons = 0, cyc = 0, seed = 51869, i;
    logic [3:0] b;
    always #2 clk = ~clk;
    frmc_strap_model i_strap(.mode_i(mode), .serial_i(ser), .pm_pin_o(pm), .bs_high_o(bsh), .bs_low_o(bsl),
        .par_o(par), .ser_sync_o(ssync));
    frmc_ctrl i_dut(.sys_clk_i(clk), .rst_n_i(rst_n), .processor_mode_pin_i(pm), .boot_select_high_pin_i(bsh),
        .boot_select_low_pin_i(bsl), .parallel_prog_i(par), .serial_sync_i(ssync), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .cpu_addr_i(caddr), .boot_area_select_o(boot_sel),
        .ext_area_enable_o(ext_en), .cs2_area_hit_o(cs2), .extra_block_enable_o(xblk), .cmd_start_o(cst),
        .cmd_code_o(ccode), .cmd_block_o(cblk), .cmd_byte_o(cbyte));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Read answers and command pulses are matched against the oldest note
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test;
        end
        if (rd && wreq === 1'b0) chk(rdata & mq.pop_front(), rq.pop_front());
        if (cst === 1'b1) chk({ccode, cblk}, (cq.size() > 0) ? cq.pop_front() : 7'h7F);
    end
    // Master holds the request until it samples waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        rd <= 0;
        wr <= 0;
    endtask
    task rd_exp(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back(e & m);
        mq.push_back(m);
        bus(0, a, 32'h0);
    endtask
    task cmd(input logic [31:0] d, input logic ok);
        if (ok) cq.push_back({d[2:0], d[11:8]});
        bus(1, 4'hC, d);
    endtask
    // Straps settle during the whole reset so the synchronisers are full
    task start(input logic [1:0] m);
        @(posedge clk);
        rst_n <= 0;
        mode <= m;
        ser <= $random(seed);
        repeat (5) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
    endtask
    task probe(input logic [19:0] a);
        @(posedge clk);
        caddr <= a;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        start(0);
        rd_exp(4'h8, 0, 32'h7);
        rd_exp(4'h0, 0, 32'hFF);
        rd_exp(4'h4, 0, 32'hFF);
        rd_exp(4'h2, 0, 32'hFFFFFFFF);
        chk(boot_sel, 0);
        bus(1, 4'h0, 32'h6);
        rd_exp(4'h0, 32'h6, 32'h6);
        rd_exp(4'h4, 32'h9, 32'h9);
        bus(1, 4'h4, 32'h1);
        rd_exp(4'h8, 32'h40, 32'h40);
        probe(20'h10000 + ($random(seed) & 20'h0FFFF));
        chk(cs2, 1);
        for (i = 0; i < 8; i++) begin
            b = $random(seed) & 4'h7;
            cmd({b, 8'h00} | i, 1);
        end
        cmd(32'h306, 1);
        cmd(32'h303, 0);
        rd_exp(4'h8, 32'h20, 32'h20);
        cmd(32'h304, 0);
        cmd(32'h305, 1);
        cmd(32'h303, 1);
        cmd(32'h10303, 0);
        cmd(32'h40303, 0);
        rd_exp(4'h8, 32'h20, 32'h20);
        bus(1, 4'h0, 32'h0);
        rd_exp(4'h8, 0, 32'h40);
        probe(20'h40000 + ($random(seed) & 20'h3FFFF));
        chk(ext_en, 0);
        start(2);
        rd_exp(4'h8, 2, 32'h7);
        chk(boot_sel, 1);
        bus(1, 4'h0, 32'h26);
        rd_exp(4'h0, 32'h22, 32'h26);
        chk(boot_sel, 1);
        start(1);
        rd_exp(4'h8, 1, 32'h7);
        start(3);
        rd_exp(4'h8, 3, 32'h7);
        bus(1, 4'h0, 32'h2);
        cmd(32'h50F03, 1);
        repeat (4) @(posedge clk);
        chk(cq.size(), 0);
        end_of_test;
    end
endmodule
